// ### bench/ledc_cfg_regs_sva.sv
// port assertions of the led configuration block
`timescale 1ns/100ps
module ledc_chk
    import ledc_pkg::*;
#(
    parameter int CHANNELS = 16
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_valid_i,
    input wire ledc_wr_kind_t wr_kind_i,
    input wire logic [15:0] wr_data_i,
    input wire logic [CHANNELS-1:0] fault_raw_i,
    input wire logic dim_sync_pin_oe_o,
    input wire logic [15:0] device_config_0_o,
    input wire ledc_cfg1_t device_config_1_o,
    input wire logic [15:0] channel_enable_mask_o,
    input wire logic [CHANNELS-1:0] channel_fault_status_o,
    input wire ledc_short_t short_threshold_o,
    input wire logic status_stream_active_o,
    input wire logic [CHANNELS-1:0] channel_out_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // config word handed over, and its unlocked second-register form
    sequence s_cfg_wr;
        wr_valid_i && wr_kind_i == LEDC_WR_CONFIG;
    endsequence
    sequence s_cfg1_free;
        s_cfg_wr ##0 (wr_data_i[15] && !device_config_0_o[0]);
    endsequence
    a_reset_vals: assert property ($fell(sys_rst_i) |-> device_config_1_o == 16'h0040
        && device_config_0_o == 16'h0000 && channel_enable_mask_o == 16'h0000) else $error("bad reset value");
    a_cfg1_load: assert property (s_cfg1_free |=> device_config_1_o[14:0] == $past(wr_data_i[14:0]))
        else $error("second config word not loaded");
    a_cfg0_keeps: assert property (s_cfg_wr ##0 !wr_data_i[15] |=> $stable(device_config_1_o))
        else $error("second config word disturbed");
    a_sync_lock: assert property (s_cfg_wr ##0 device_config_0_o[0] |=>
        $stable(device_config_1_o.sync_direction_select)) else $error("sync direction changed while enabled");
    a_short_code: assert property (s_cfg_wr ##0 !wr_data_i[15] |=> ##1
        short_threshold_o == $past(wr_data_i[9:8], 2)) else $error("threshold decode wrong");
    a_mask_load: assert property (wr_valid_i && wr_kind_i == LEDC_WR_MASK |=>
        channel_enable_mask_o == $past(wr_data_i)) else $error("mask not loaded");
    a_fault_gate: assert property (!$past(sys_rst_i) |->
        channel_fault_status_o == ($past(fault_raw_i) & $past(channel_enable_mask_o))) else $error("fault not masked");
    a_chan_off: assert property ((channel_out_o & ~$past(channel_enable_mask_o)) == '0)
        else $error("disabled channel driven");
    a_stream_gate: assert property (!$past(sys_rst_i) |-> status_stream_active_o ==
        ($past(device_config_1_o.status_stream_enable) && $past(device_config_1_o.frame_format_select)))
        else $error("status stream gating wrong");
    a_pin_dir: assert property (dim_sync_pin_oe_o == !device_config_1_o.sync_direction_select)
        else $error("sync pin direction wrong");
endmodule : ledc_chk

bind ledc_cfg_regs ledc_chk #(.CHANNELS(CHANNELS)) chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .wr_valid_i(wr_valid_i), .wr_kind_i(wr_kind_i), .wr_data_i(wr_data_i), .fault_raw_i(fault_raw_i),
    .dim_sync_pin_oe_o(dim_sync_pin_oe_o), .device_config_0_o(device_config_0_o),
    .device_config_1_o(device_config_1_o), .channel_enable_mask_o(channel_enable_mask_o),
    .channel_fault_status_o(channel_fault_status_o), .short_threshold_o(short_threshold_o),
    .status_stream_active_o(status_stream_active_o), .channel_out_o(channel_out_o));

// ### bench/ledc_host_model.sv
// host side model feeding words, brightness and the latch strobe
`timescale 1ns/100ps
module ledc_host_model
    import ledc_pkg::*;
(
    input wire logic core_clk_i,
    output logic wr_valid_o,
    output ledc_wr_kind_t wr_kind_o,
    output logic [15:0] wr_data_o,
    output logic brt_wr_o,
    output logic [3:0] brt_idx_o,
    output logic [15:0] brt_data_o,
    output logic latch_strobe_o
);
    // idle levels at time zero
    initial begin
        wr_valid_o = 1'b0;
        wr_kind_o = LEDC_WR_MASK;
        wr_data_o = 16'h0000;
        brt_wr_o = 1'b0;
        brt_idx_o = 4'h0;
        brt_data_o = 16'h0000;
        latch_strobe_o = 1'b0;
    end
    // one whole word, released data inverted so stale values never match
    task automatic send_word(input ledc_wr_kind_t kind, input logic [15:0] data);
        @(negedge core_clk_i);
        wr_valid_o = 1'b1;
        wr_kind_o = kind;
        wr_data_o = data;
        @(negedge core_clk_i);
        wr_valid_o = 1'b0;
        wr_data_o = ~data;
        @(negedge core_clk_i);
    endtask : send_word
    // one brightness entry into the holding buffer
    task automatic send_brt(input logic [3:0] idx, input logic [15:0] data);
        @(negedge core_clk_i);
        brt_wr_o = 1'b1;
        brt_idx_o = idx;
        brt_data_o = data;
        @(negedge core_clk_i);
        brt_wr_o = 1'b0;
        brt_data_o = ~data;
    endtask : send_brt
    // strobe pulse, then time for the synchronised fall to land
    task automatic strobe;
        @(negedge core_clk_i);
        latch_strobe_o = 1'b1;
        repeat (3) @(negedge core_clk_i);
        latch_strobe_o = 1'b0;
        repeat (6) @(negedge core_clk_i);
    endtask : strobe
endmodule : ledc_host_model

// ### bench/testbench.sv
// self-checking bench of the led configuration block
`timescale 1ns/100ps
module testbench
    import ledc_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic gs_tick = 1'b0;
    logic [15:0] fault_raw = 16'h0000;
    logic trig = 1'b0;
    logic wr_valid, brt_wr, strobe, pin_o, pin_oe, stream, cyc_end;
    ledc_wr_kind_t kind;
    logic [15:0] wdata, bdata, cfg0, mask, fstat, chan;
    logic [3:0] bidx;
    ledc_cfg1_t cfg1;
    ledc_short_t thr;
    logic [255:0] brt;
    int err_total = 0;
    int num_checks = 0;
    // clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    ledc_host_model host (.core_clk_i(core_clk), .wr_valid_o(wr_valid), .wr_kind_o(kind), .wr_data_o(wdata),
        .brt_wr_o(brt_wr), .brt_idx_o(bidx), .brt_data_o(bdata), .latch_strobe_o(strobe));
    ledc_cfg_regs dut (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .wr_valid_i(wr_valid), .wr_kind_i(kind),
        .wr_data_i(wdata), .brt_wr_i(brt_wr), .brt_idx_i(bidx), .brt_data_i(bdata), .latch_strobe_i(strobe),
        .gs_tick_i(gs_tick), .dim_sync_pin_i(trig), .fault_raw_i(fault_raw), .dim_sync_pin_o(pin_o),
        .dim_sync_pin_oe_o(pin_oe), .device_config_0_o(cfg0), .device_config_1_o(cfg1),
        .channel_enable_mask_o(mask), .channel_fault_status_o(fstat), .short_threshold_o(thr),
        .status_stream_active_o(stream), .brightness_active_o(brt), .channel_out_o(chan), .cycle_end_o(cyc_end));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cfg(input logic [15:0] d);
        host.send_word(LEDC_WR_CONFIG, d);
    endtask : cfg
    task automatic wait_end;
        int n;
        n = 0;
        while (cyc_end !== 1'b1 && n < 70000) begin
            @(negedge core_clk);
            n++;
        end
    endtask : wait_end
    // one full dimming period: length, on count of channel 0, its early phase
    task automatic run_period(output int g, output int on0, output logic ph);
        wait_end();
        @(negedge core_clk);
        wait_end();
        g = 0;
        on0 = 0;
        ph = 1'b0;
        do begin
            @(negedge core_clk);
            g++;
            on0 += int'(chan[0]);
            if (g == 5) ph = chan[0];
        end while (cyc_end !== 1'b1 && g < 70000);
    endtask : run_period
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // watchdog
    initial begin
        #300000;
        err_total++;
        wrap_up();
    end
    // test sequence
    initial begin
        int g0, g1, on;
        logic ph;
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        chk("cfg1 reset", 16'h0040, cfg1);
        chk("pin oe reset", 16'h0001, {15'h0, pin_oe});
        $display("test reset done");
        cfg(16'hffff);
        chk("cfg1 all", 16'h7fff, {1'b0, cfg1[14:0]});
        chk("cfg0 kept", 16'h0000, cfg0);
        chk("pin oe in", 16'h0000, {15'h0, pin_oe});
        chk("stream on", 16'h0001, {15'h0, stream});
        cfg(16'hc400);
        chk("stream word fmt", 16'h0000, {15'h0, stream});
        cfg(16'h8600);
        chk("long frame", 16'h0600, {1'b0, cfg1[14:0]});
        for (int c = 0; c < 4; c++) begin
            cfg({6'h00, c[1:0], 8'h00});
            chk("threshold", 16'(c), {14'h0, thr});
        end
        $display("test config done");
        host.send_word(LEDC_WR_MASK, 16'ha5c3);
        fault_raw = 16'hffff;
        @(negedge core_clk);
        chk("mask", 16'ha5c3, mask);
        chk("fault", 16'ha5c3, fstat);
        $display("test mask done");
        cfg(16'h8000);
        cfg(16'h0001);
        cfg(16'ha400);
        chk("sync locked", 16'h0400, {1'b0, cfg1[14:0]});
        chk("pin oe locked", 16'h0001, {15'h0, pin_oe});
        $display("test lock done");
        gs_tick = 1'b1;
        cfg(16'h8000);
        host.send_brt(4'h3, 16'h1234);
        repeat (3) @(negedge core_clk);
        chk("held in buffer", 16'h0000, brt[63:48]);
        host.strobe();
        chk("applied at strobe", 16'h1234, brt[63:48]);
        cfg(16'h9000);
        host.send_brt(4'h3, 16'h5678);
        host.strobe();
        chk("deferred", 16'h1234, brt[63:48]);
        wait_end();
        @(negedge core_clk);
        chk("sync pulse", 16'h0001, {15'h0, pin_o});
        @(negedge core_clk);
        chk("sync pulse end", 16'h0000, {15'h0, pin_o});
        chk("applied at end", 16'h5678, brt[63:48]);
        $display("test update done");
        host.send_word(LEDC_WR_MASK, 16'h0001);
        host.send_brt(4'h0, 16'hf800);
        host.send_brt(4'h1, 16'hffff);
        host.strobe();
        run_period(g0, on, ph);
        chk("duty 12 bit", 16'h0800, 16'(on));
        chk("off first", 16'h0000, {15'h0, ph});
        cfg(16'h9800);
        run_period(g1, on, ph);
        chk("duty inverted", 16'h0800, 16'(on));
        chk("on first", 16'h0001, {15'h0, ph});
        host.send_word(LEDC_WR_LATENCY, 16'h0014);
        run_period(g1, on, ph);
        chk("latency period", 16'(g0 + 20), 16'(g1));
        // trigger input mode: engine idles after a period until the pin rises
        cfg(16'h0000);
        cfg(16'ha800);
        cfg(16'h0001);
        chk("pin oe trigger", 16'h0000, {15'h0, pin_oe});
        wait_end();
        repeat (100) @(negedge core_clk);
        chk("waits for trigger", 16'h0000, chan);
        trig = 1'b1;
        repeat (30) @(negedge core_clk);
        chk("started by trigger", 16'h0001, chan);
        $display("test dimming done");
        wrap_up();
    end
endmodule : testbench

// ### pkg/ledc_defs.svh
// constants of the led driver configuration block
`ifndef LEDC_DEFS_SVH
`define LEDC_DEFS_SVH
// ----------------------------------------
// reset values
// ----------------------------------------
`define LEDC_CFG0_RST 16'h0000
`define LEDC_CFG1_RST 16'h0040
`define LEDC_LAT_RST 16'h0000
`define LEDC_MASK_RST 16'h0000
// ----------------------------------------
// field positions
// ----------------------------------------
`define LEDC_CFG0_EN_BIT 0
`define LEDC_CFG0_SHORT_LO_BIT 8
`define LEDC_CFG0_SHORT_HI_BIT 9
`define LEDC_CFG0_RANGE_BIT 11
`define LEDC_CFG0_SLAVE_BIT 14
`define LEDC_TARGET_BIT 15
// ----------------------------------------
// dimming counter limits
// ----------------------------------------
`define LEDC_MAX_12 16'h0fff
`define LEDC_MAX_16 16'hffff
`endif

// ### pkg/ledc_pkg.sv
// types of the led driver configuration block
package ledc_pkg;
    // kind of word handed over by the serial framing
    typedef enum logic [1:0] {
        LEDC_WR_CONFIG,
        LEDC_WR_LATENCY,
        LEDC_WR_MASK
    } ledc_wr_kind_t;

    // dimming engine phases
    typedef enum logic [1:0] {
        LEDC_ST_WAIT,
        LEDC_ST_LAT,
        LEDC_ST_PWM
    } ledc_state_t;

    // decoded short detection threshold
    typedef enum logic [1:0] {
        LEDC_SHORT_OFF,
        LEDC_SHORT_3V4,
        LEDC_SHORT_6V8,
        LEDC_SHORT_8V4
    } ledc_short_t;

    // second configuration word, msb first
    typedef struct packed {
        logic config_target_select;
        logic status_stream_enable;
        logic sync_direction_select;
        logic update_sync_select;
        logic dim_phase_invert;
        logic brightness_width_select;
        logic frame_format_select;
        logic [1:0] latency_hi;
        logic gain_range_select;
        logic [5:0] current_gain_trim;
    } ledc_cfg1_t;
endpackage : ledc_pkg

// ### rtl/ledc_cfg_regs.sv
// configuration registers and dimming engine of the led driver
//
// Behaviour
// RULE1: gain trim bits 0-5, range bit 6 resets 1
// RULE2: bits 7-8 are latency bits 16-17
// RULE3: bit 9 selects word or long frame
// RULE4: bit 10 selects 12 or 16-bit width
// RULE5: bit 11 selects off or on phase first
// RULE6: sync 0 applies brightness at strobe fall
// RULE7: sync 1 applies brightness at cycle end
// RULE8: bit 13 sets sync pin output or input
// RULE9: bit 14 enables continuous status readback
// RULE10: word bit 15 picks config register
// RULE11: sync direction locked while chip enabled
// RULE12: threshold code off, 3.4, 6.8, 8.4 V
// RULE13: latency delay starts every dimming period
// RULE14: latency low register write-only, 16 bits
// RULE15: channel mask readable writable 16 bits
// RULE16: masked-off channel output kept off
// RULE17: host uses 16-bit width with 256-bit frame
// RULE18: status readback only in long frame format
// RULE19: masked-off channels report no fault
// RULE20: brightness staged in 256-bit holding buffer
// RULE21: 12-bit mode ignores upper four bits
// RULE22: latency sampled at each period start
`timescale 1ns/100ps
`include "ledc_defs.svh"

module ledc_cfg_regs
    import ledc_pkg::*;
#(
    parameter int CHANNELS = 16,
    parameter int LAT_W = 18
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_valid_i,
    input wire ledc_wr_kind_t wr_kind_i,
    input wire logic [15:0] wr_data_i,
    input wire logic brt_wr_i,
    input wire logic [3:0] brt_idx_i,
    input wire logic [15:0] brt_data_i,
    input wire logic latch_strobe_i,
    input wire logic gs_tick_i,
    input wire logic dim_sync_pin_i,
    input wire logic [CHANNELS-1:0] fault_raw_i,
    output logic dim_sync_pin_o,
    output logic dim_sync_pin_oe_o,
    output logic [15:0] device_config_0_o,
    output ledc_cfg1_t device_config_1_o,
    output logic [15:0] channel_enable_mask_o,
    output logic [CHANNELS-1:0] channel_fault_status_o,
    output ledc_short_t short_threshold_o,
    output logic status_stream_active_o,
    output logic [CHANNELS*16-1:0] brightness_active_o,
    output logic [CHANNELS-1:0] channel_out_o,
    output logic cycle_end_o
);
    // ----------------------------------------
    // registers and internal state
    // ----------------------------------------
    logic [15:0] device_config_0;
    ledc_cfg1_t device_config_1;
    logic [15:0] dim_latency_low;
    logic [15:0] channel_enable_mask;
    logic [15:0] hold_buf [CHANNELS];
    logic [15:0] active_buf [CHANNELS];
    logic update_pending;
    logic [2:0] strobe_sync;
    logic [2:0] trig_sync;
    ledc_state_t state;
    logic [LAT_W-1:0] lat_cnt;
    logic [15:0] dim_cnt;
    logic sync_pulse;
    logic chip_enable;
    logic strobe_fall;
    logic trig_rise;
    logic [15:0] dim_max;
    logic [LAT_W-1:0] lat_full;
    logic period_end;
    logic period_start;
    logic apply_update;
    ledc_cfg1_t wr_cfg1;

    // mask brightness to the selected width
    function automatic logic [15:0] ledc_width_mask(input logic [15:0] value, input logic wide);
        ledc_width_mask = wide ? value : (value & `LEDC_MAX_12); // see RULE21
    endfunction : ledc_width_mask

    // ----------------------------------------
    // decoding
    // ----------------------------------------
    assign chip_enable = device_config_0[`LEDC_CFG0_EN_BIT];
    assign strobe_fall = strobe_sync[2] & ~strobe_sync[1];
    assign trig_rise = trig_sync[1] & ~trig_sync[2];
    assign wr_cfg1 = ledc_cfg1_t'(wr_data_i);
    // counter end follows the width bit
    assign dim_max = device_config_1.brightness_width_select ? `LEDC_MAX_16 : `LEDC_MAX_12; // see RULE4
    // 18-bit latency from both registers
    assign lat_full = {device_config_1.latency_hi, dim_latency_low}; // see RULE2
    assign period_end = gs_tick_i && (state == LEDC_ST_PWM) && (dim_cnt == dim_max);
    // new period on trigger in input mode, else right after the last one
    assign period_start = device_config_1.sync_direction_select
        ? (trig_rise && (state == LEDC_ST_WAIT)) // see RULE8
        : ((gs_tick_i && (state == LEDC_ST_WAIT)) || period_end);
    // buffer transfer moment depends on the sync bit
    assign apply_update = device_config_1.update_sync_select
        ? (period_end && (update_pending || strobe_fall)) // see RULE7
        : strobe_fall; // see RULE6

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // two flops before use, third for edge detection
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            strobe_sync <= 3'h0;
            trig_sync <= 3'h0;
        end else begin
            strobe_sync <= {strobe_sync[1:0], latch_strobe_i};
            trig_sync <= {trig_sync[1:0], dim_sync_pin_i};
        end
    end

    // ----------------------------------------
    // configuration words
    // ----------------------------------------
    // first configuration word, guarded bits locked while enabled
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            device_config_0 <= `LEDC_CFG0_RST;
        end else if (wr_valid_i && wr_kind_i == LEDC_WR_CONFIG && !wr_data_i[`LEDC_TARGET_BIT]) begin // see RULE10
            device_config_0 <= wr_data_i;
            if (chip_enable) begin
                device_config_0[`LEDC_CFG0_RANGE_BIT] <= device_config_0[`LEDC_CFG0_RANGE_BIT];
                device_config_0[`LEDC_CFG0_SLAVE_BIT] <= device_config_0[`LEDC_CFG0_SLAVE_BIT];
            end
        end
    end

    // second configuration word
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            device_config_1 <= ledc_cfg1_t'(`LEDC_CFG1_RST); // see RULE1
        end else if (wr_valid_i && wr_kind_i == LEDC_WR_CONFIG && wr_data_i[`LEDC_TARGET_BIT]) begin // see RULE10
            device_config_1 <= wr_cfg1; // see RULE1
            if (chip_enable) begin
                device_config_1.sync_direction_select <= device_config_1.sync_direction_select; // see RULE11
            end
        end
    end

    // ----------------------------------------
    // latency and channel mask
    // ----------------------------------------
    // latency low word, never read back
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            dim_latency_low <= `LEDC_LAT_RST;
        end else if (wr_valid_i && wr_kind_i == LEDC_WR_LATENCY) begin
            dim_latency_low <= wr_data_i; // see RULE14
        end
    end

    // channel enable mask
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            channel_enable_mask <= `LEDC_MASK_RST;
        end else if (wr_valid_i && wr_kind_i == LEDC_WR_MASK) begin
            channel_enable_mask <= wr_data_i; // see RULE15
        end
    end

    // ----------------------------------------
    // brightness buffers
    // ----------------------------------------
    // holding buffer loaded word by word
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < CHANNELS; i++) begin
                hold_buf[i] <= 16'h0000;
            end
        end else if (brt_wr_i) begin
            hold_buf[brt_idx_i] <= brt_data_i; // see RULE20
        end
    end

    // active registers fed only from the holding buffer
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < CHANNELS; i++) begin
                active_buf[i] <= 16'h0000;
            end
        end else if (apply_update) begin
            for (int i = 0; i < CHANNELS; i++) begin
                active_buf[i] <= hold_buf[i]; // see RULE20
            end
        end
    end

    // deferred update flag, a strobe at cycle end is served at once
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            update_pending <= 1'b0;
        end else if (!device_config_1.update_sync_select || period_end) begin
            update_pending <= 1'b0; // see RULE7
        end else if (strobe_fall) begin
            update_pending <= 1'b1;
        end
    end

    // ----------------------------------------
    // dimming engine
    // ----------------------------------------
    // latency phase then pwm phase, on grayscale ticks
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state <= LEDC_ST_WAIT;
            lat_cnt <= '0;
            dim_cnt <= 16'h0000;
        end else if (period_start) begin
            lat_cnt <= lat_full; // see RULE22
            dim_cnt <= 16'h0000;
            state <= (lat_full == '0) ? LEDC_ST_PWM : LEDC_ST_LAT; // see RULE13
        end else if (period_end) begin
            state <= LEDC_ST_WAIT;
        end else if (gs_tick_i) begin
            unique case (state)
                LEDC_ST_WAIT: begin
                    state <= LEDC_ST_WAIT;
                end
                LEDC_ST_LAT: begin
                    lat_cnt <= lat_cnt - 1'b1; // see RULE13
                    if (lat_cnt == LAT_W'(1)) begin
                        state <= LEDC_ST_PWM;
                    end
                end
                LEDC_ST_PWM: begin
                    dim_cnt <= dim_cnt + 16'h0001;
                end
            endcase
        end
    end

    // one-cycle pulse on the sync pin at each period start, in output mode only
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sync_pulse <= 1'b0;
        end else begin
            sync_pulse <= period_start && !device_config_1.sync_direction_select; // see RULE8
        end
    end

    // ----------------------------------------
    // channel outputs
    // ----------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            logic [15:0] level;
            logic [16:0] off_len;
            logic on_now;
            assign level = ledc_width_mask(active_buf[ch], device_config_1.brightness_width_select);
            assign off_len = {1'b0, dim_max} + 17'h00001 - {1'b0, level};
            // off phase first waits until only the on time is left
            assign on_now = device_config_1.dim_phase_invert
                ? ({1'b0, dim_cnt} < {1'b0, level}) // see RULE5
                : ({1'b0, dim_cnt} >= off_len); // see RULE5
            always_ff @(posedge core_clk_i) begin
                if (sys_rst_i) begin
                    channel_out_o[ch] <= 1'b0;
                end else begin
                    channel_out_o[ch] <= chip_enable && channel_enable_mask[ch]
                        && (state == LEDC_ST_PWM) && on_now; // see RULE16
                end
            end
            assign brightness_active_o[ch*16 +: 16] = active_buf[ch];
        end
    endgenerate

    // ----------------------------------------
    // status outputs
    // ----------------------------------------
    // fault bits of masked channels forced low
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            channel_fault_status_o <= '0;
        end else begin
            channel_fault_status_o <= fault_raw_i & channel_enable_mask[CHANNELS-1:0]; // see RULE19
        end
    end

    // readback only with the enable bit and the long frame
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            status_stream_active_o <= 1'b0;
        end else begin
            status_stream_active_o <= device_config_1.status_stream_enable // see RULE9
                && device_config_1.frame_format_select; // see RULE18
        end
    end

    // threshold code from the first configuration word
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            short_threshold_o <= LEDC_SHORT_OFF;
        end else begin
            short_threshold_o <= ledc_short_t'({device_config_0[`LEDC_CFG0_SHORT_HI_BIT],
                device_config_0[`LEDC_CFG0_SHORT_LO_BIT]}); // see RULE12
        end
    end

    // register copies and pin drive
    assign device_config_0_o = device_config_0;
    assign device_config_1_o = device_config_1; // see RULE3
    assign channel_enable_mask_o = channel_enable_mask;
    assign dim_sync_pin_o = sync_pulse;
    assign dim_sync_pin_oe_o = !device_config_1.sync_direction_select;
    assign cycle_end_o = period_end;
endmodule : ledc_cfg_regs
